// ==== flow_switch.sv ====
`timescale 1ns/1ns
// =====================================================================
// flow switch model: contact closes some cycles after the valve opens
module flow_switch (
  input wire ref_clk,
  input wire open_cmd,
  output logic flow_ok
);
  int wait_q;
  initial flow_ok = 1'b0;
  // travel time varies so both prompt and slow valves are seen
  always @(posedge ref_clk) begin
    if (!open_cmd) begin
      flow_ok <= 1'b0;
      wait_q <= 2 + $urandom % 4;
    end else if (wait_q > 0) begin
      wait_q <= wait_q - 1;
    end else begin
      flow_ok <= 1'b1;
    end
  end
endmodule // flow_switch

// ==== pump_checker_sva.sv ====
`timescale 1ns/1ns
`include "pump_consts.vh"
// =====================================================================
// port checker
module pump_checker (
  input wire ref_clk,
  input wire rst_b,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_ack_o,
  input wire stop_pin,
  input wire run_normal,
  input wire flow_verifying,
  input wire trip,
  input wire [`ALARM_W-1:0] alarm_code
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_b);
  property p_ack_pulse; wb_ack_o |=> !wb_ack_o; endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack held too long");
  property p_ack_resp; wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o; endproperty
  a_ack_resp: assert property (p_ack_resp) else $error("ack missing");
  property p_alarm_trip; trip |-> alarm_code == `ALARM_NO_FLOW || alarm_code == `ALARM_LOW_SPEED; endproperty
  a_alarm_trip: assert property (p_alarm_trip) else $error("trip without alarm");
  property p_trip_stop; trip |-> !run_normal && !flow_verifying; endproperty
  a_trip_stop: assert property (p_trip_stop) else $error("running while tripped");
  property p_verify_run; flow_verifying |-> !run_normal; endproperty
  a_verify_run: assert property (p_verify_run) else $error("running before flow confirmed");
  property p_stop_idle; stop_pin [*5] |-> !flow_verifying && !run_normal; endproperty
  a_stop_idle: assert property (p_stop_idle) else $error("stop ignored");
  property p_alarm_hold; trip && $past(trip) |-> $stable(alarm_code); endproperty
  a_alarm_hold: assert property (p_alarm_hold) else $error("alarm changed in trip");
  property p_trip_hold; !wb_cyc_i [*4] ##0 trip |=> trip; endproperty
  a_trip_hold: assert property (p_trip_hold) else $error("trip cleared without bus");
  c_trip: cover property (trip);
  c_verify: cover property (flow_verifying);
  c_stop: cover property (stop_pin && flow_verifying);
endmodule // pump_checker
bind pump_start_flow_supervisor pump_checker u_pump_checker (.ref_clk, .rst_b, .wb_cyc_i, .wb_stb_i,
  .wb_ack_o, .stop_pin, .run_normal, .flow_verifying, .trip, .alarm_code);

// ==== pump_consts.vh ====
`ifndef PUMP_SUPERVISOR_CONSTS_VH
`define PUMP_SUPERVISOR_CONSTS_VH
// =====================================================================
// clock and time base
`define CLK_HZ 100000000
`define TICK_MS 100
`define TICK_CYCLES ((`CLK_HZ / 1000) * `TICK_MS)
`define TICK_CNT_W 24
`define TIME_W 14
// =====================================================================
// register map (word offsets are byte addresses)
`define REG_CTRL 8'h00
`define REG_VALID_TIME 8'h04
`define REG_VERIFY_TIME 8'h08
`define REG_HOLDOFF 8'h0c
`define REG_DEADLINE 8'h10
`define REG_SPEED_FLOOR 8'h14
`define REG_STATUS 8'h18
`define REG_ALARM 8'h1c
// =====================================================================
// field positions and widths
`define CTRL_FLOW_EN 0
`define CTRL_SPEED_EN 1
`define CTRL_CLR_TRIP 2
`define ST_VERIFYING 0
`define ST_RUNNING 1
`define ST_TRIPPED 2
`define ST_STATE_LSB 4
`define SPEED_W 16
`define ALARM_W 8
// =====================================================================
// reset values and limits; times in tenths of a second
`define RST_VALID_TIME 14'd100
`define RST_VERIFY_TIME 14'd150
`define RST_HOLDOFF 14'd0
`define RST_DEADLINE 14'd300
`define RST_SPEED_FLOOR 16'h0000
`define MIN_TIME 14'd1
`define MAX_VALID_TIME 14'd9990
`define MAX_VERIFY_TIME 14'd2550
// =====================================================================
// alarm codes
`define ALARM_NONE 8'h00
`define ALARM_NO_FLOW 8'h5c
`define ALARM_LOW_SPEED 8'h5d
`endif

// ==== pump_start_flow_supervisor.v ====
// Our own choices: the address map and the Wishbone register port.
`timescale 1ns/1ns
`include "pump_consts.vh"
// What this block does
// - On start, a validation timer runs and flow-confirm must go active before it ends (0.1 to 999.0 s).
// - After flow is seen, a verification period runs, the input is sampled again at its end, then running starts.
// - Flow-confirm dropping during validation or verification trips with no-flow alarm 92.
// - Flow counts as confirmed only if still active at the end of verification (0.1 to 255.0 s, default 15).
// - A flow-verifying indication goes to the operator panel while the flow monitor is active.
// - Flow supervision applies only when a digital input is assigned the flow-confirm function.
// - The block trips if speed has not reached the trip-speed floor before the start-speed deadline.
// - Hold-off and start-speed deadline timers both start at the start command.
// - With speed supervision on, if hold-off is at or above the deadline, the block never enters running.
// - In normal operation, speed below the trip-speed floor trips, whatever lowered it.
module pump_start_flow_supervisor (
  input wire ref_clk,
  input wire rst_b,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [7:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  output reg [31:0] wb_dat_o,
  output reg wb_ack_o,
  input wire start_pin,
  input wire stop_pin,
  input wire flow_confirm_pin,
  input wire [`SPEED_W-1:0] motor_speed,
  output reg ramp_enable,
  output reg run_normal,
  output reg flow_verifying,
  output reg trip,
  output reg [`ALARM_W-1:0] alarm_code
);
  // =====================================================================
  // states
  localparam [2:0] S_IDLE = 3'd0;
  localparam [2:0] S_VALIDATE = 3'd1;
  localparam [2:0] S_VERIFY = 3'd2;
  localparam [2:0] S_SPEEDUP = 3'd3;
  localparam [2:0] S_RUN = 3'd4;
  localparam [2:0] S_TRIP = 3'd5;

  // clamp a written time into its legal range
  function [`TIME_W-1:0] clamp_time;
    input [31:0] v;
    input [`TIME_W-1:0] hi;
    begin
      if (v < {18'h00000, `MIN_TIME})
        clamp_time = `MIN_TIME;
      else if (v > {18'h00000, hi})
        clamp_time = hi;
      else
        clamp_time = v[`TIME_W-1:0];
    end
  endfunction

  // supervision is live in every state but idle and trip; the common
  // start timer and the stop path both key off this
  function supervising;
    input [2:0] st;
    begin
      supervising = (st != S_IDLE) && (st != S_TRIP);
    end
  endfunction

  // =====================================================================
  // synchronised pins and time base
  localparam N_PINS = 3;
  wire start_s;
  wire stop_s;
  wire flow_s;
  wire tick;
  wire [N_PINS-1:0] pin_raw;
  wire [N_PINS-1:0] pin_s;

  // pins are gathered into one vector so a single loop synchronises them
  assign pin_raw = {flow_confirm_pin, stop_pin, start_pin};
  assign start_s = pin_s[0];
  assign stop_s = pin_s[1];
  assign flow_s = pin_s[2];

  // every pin crosses into the clock domain through its own two-flop stage;
  // this costs two cycles of latency on start, stop and flow alike
  genvar gi;
  generate
    for (gi = 0; gi < N_PINS; gi = gi + 1) begin : g_pin_sync
      sync2 u_sync2 (
        .ref_clk(ref_clk),
        .rst_b(rst_b),
        .din(pin_raw[gi]),
        .dout(pin_s[gi])
      );
    end
  endgenerate

  // tenth-second enable shared by every supervision timer
  tick_divider u_tick_divider (
    .ref_clk(ref_clk),
    .rst_b(rst_b),
    .tick(tick)
  );

  // =====================================================================
  // registers
  reg flow_en_q;
  reg speed_en_q;
  reg [`TIME_W-1:0] valid_time_q;
  reg [`TIME_W-1:0] verify_time_q;
  reg [`TIME_W-1:0] holdoff_q;
  reg [`TIME_W-1:0] deadline_q;
  reg [`SPEED_W-1:0] speed_floor_q;
  reg [2:0] state_q;
  reg [`TIME_W-1:0] phase_cnt_q;
  reg [`TIME_W-1:0] start_cnt_q;
  reg start_d1_q;
  reg clr_trip_q;

  wire wr_en = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o && (&wb_sel_i);
  wire rd_en = wb_cyc_i && wb_stb_i && !wb_we_i && !wb_ack_o;
  wire start_evt = start_s && !start_d1_q;
  wire holdoff_done = start_cnt_q >= holdoff_q;
  wire deadline_hit = start_cnt_q >= deadline_q;
  wire below_floor = motor_speed < speed_floor_q;

  // status and control words; bit positions come from the header
  reg [31:0] status_word;
  reg [31:0] ctrl_word;
  always @* begin
    status_word = 32'h00000000;
    status_word[`ST_VERIFYING] = flow_verifying;
    status_word[`ST_RUNNING] = run_normal;
    status_word[`ST_TRIPPED] = trip;
    status_word[`ST_STATE_LSB +: 3] = state_q;
    ctrl_word = 32'h00000000;
    ctrl_word[`CTRL_FLOW_EN] = flow_en_q;
    ctrl_word[`CTRL_SPEED_EN] = speed_en_q;
  end

  // bus answer: ack one cycle after the request and low for a cycle after it;
  // read data is registered at the same edge so it stands while ack is high
  always @(posedge ref_clk) begin
    if (!rst_b) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
    end else begin
      wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o;
      if (rd_en) begin
        case (wb_adr_i)
          `REG_CTRL: wb_dat_o <= ctrl_word;
          `REG_VALID_TIME: wb_dat_o <= {18'h00000, valid_time_q};
          `REG_VERIFY_TIME: wb_dat_o <= {18'h00000, verify_time_q};
          `REG_HOLDOFF: wb_dat_o <= {18'h00000, holdoff_q};
          `REG_DEADLINE: wb_dat_o <= {18'h00000, deadline_q};
          `REG_SPEED_FLOOR: wb_dat_o <= {16'h0000, speed_floor_q};
          `REG_STATUS: wb_dat_o <= status_word;
          `REG_ALARM: wb_dat_o <= {24'h000000, alarm_code};
          default: wb_dat_o <= 32'h00000000;
        endcase
      end
    end
  end

  // =====================================================================
  // settings; partial writes are ignored, unmapped writes are acked and dropped
  always @(posedge ref_clk) begin
    if (!rst_b) begin
      flow_en_q <= 1'b0;
      speed_en_q <= 1'b0;
      clr_trip_q <= 1'b0;
      valid_time_q <= `RST_VALID_TIME;
      verify_time_q <= `RST_VERIFY_TIME;
      holdoff_q <= `RST_HOLDOFF;
      deadline_q <= `RST_DEADLINE;
      speed_floor_q <= `RST_SPEED_FLOOR;
    end else begin
      // clear-trip is a one-cycle pulse
      clr_trip_q <= 1'b0;
      if (wr_en) begin
        case (wb_adr_i)
          `REG_CTRL: begin
            flow_en_q <= wb_dat_i[`CTRL_FLOW_EN];
            speed_en_q <= wb_dat_i[`CTRL_SPEED_EN];
            clr_trip_q <= wb_dat_i[`CTRL_CLR_TRIP];
          end
          `REG_VALID_TIME: valid_time_q <= clamp_time(wb_dat_i, `MAX_VALID_TIME);
          `REG_VERIFY_TIME: verify_time_q <= clamp_time(wb_dat_i, `MAX_VERIFY_TIME);
          `REG_HOLDOFF: holdoff_q <= wb_dat_i[`TIME_W-1:0];
          `REG_DEADLINE: deadline_q <= wb_dat_i[`TIME_W-1:0];
          `REG_SPEED_FLOOR: speed_floor_q <= wb_dat_i[`SPEED_W-1:0];
          default: ;
        endcase
      end
    end
  end

  // =====================================================================
  // supervision sequencer; time counts in 100 ms ticks
  always @(posedge ref_clk) begin
    if (!rst_b) begin
      state_q <= S_IDLE;
      phase_cnt_q <= {`TIME_W{1'b0}};
      start_cnt_q <= {`TIME_W{1'b0}};
      start_d1_q <= 1'b0;
      ramp_enable <= 1'b0;
      run_normal <= 1'b0;
      flow_verifying <= 1'b0;
      alarm_code <= `ALARM_NONE;
    end else begin
      start_d1_q <= start_s;
      if (tick && supervising(state_q) && start_cnt_q != {`TIME_W{1'b1}})
        start_cnt_q <= start_cnt_q + 1'b1;
      if (tick && phase_cnt_q != {`TIME_W{1'b1}})
        phase_cnt_q <= phase_cnt_q + 1'b1;
      // ramp only after hold-off; with speed supervision on, never if hold-off reaches the deadline
      ramp_enable <= speed_en_q ? (holdoff_done && holdoff_q < deadline_q) : holdoff_done;
      case (state_q)
        S_IDLE: begin
          ramp_enable <= 1'b0;
          if (start_evt && !stop_s) begin
            start_cnt_q <= {`TIME_W{1'b0}};
            phase_cnt_q <= {`TIME_W{1'b0}};
            // flow check only when an input is assigned
            if (flow_en_q) begin
              state_q <= S_VALIDATE;
              flow_verifying <= 1'b1;
            end else
              state_q <= S_SPEEDUP;
          end
        end
        S_VALIDATE: begin
          if (flow_s) begin
            state_q <= S_VERIFY;
            phase_cnt_q <= {`TIME_W{1'b0}};
          end else if (phase_cnt_q >= valid_time_q) begin
            state_q <= S_TRIP;
            alarm_code <= `ALARM_NO_FLOW;
          end
        end
        S_VERIFY: begin
          if (!flow_s) begin
            state_q <= S_TRIP;
            alarm_code <= `ALARM_NO_FLOW;
          end else if (phase_cnt_q >= verify_time_q) begin
            state_q <= S_SPEEDUP;
            flow_verifying <= 1'b0;
          end
        end
        S_SPEEDUP: begin
          if (speed_en_q && deadline_hit && (below_floor || holdoff_q >= deadline_q)) begin
            state_q <= S_TRIP;
            alarm_code <= `ALARM_LOW_SPEED;
          end else if (holdoff_done && (!speed_en_q || (!below_floor && holdoff_q < deadline_q))) begin
            state_q <= S_RUN;
            run_normal <= 1'b1;
          end
        end
        S_RUN: begin
          if (speed_en_q && below_floor) begin
            state_q <= S_TRIP;
            run_normal <= 1'b0;
            alarm_code <= `ALARM_LOW_SPEED;
          end
        end
        S_TRIP: begin
          ramp_enable <= 1'b0;
          if (clr_trip_q) begin
            state_q <= S_IDLE;
            alarm_code <= `ALARM_NONE;
          end
        end
        default: state_q <= S_IDLE;
      endcase
      if (state_q == S_TRIP || (state_q != S_IDLE && stop_s))
        flow_verifying <= 1'b0;
      if (stop_s && supervising(state_q)) begin
        state_q <= S_IDLE;
        run_normal <= 1'b0;
        ramp_enable <= 1'b0;
        alarm_code <= `ALARM_NONE; // a trip decided in the same cycle loses to stop
        start_cnt_q <= {`TIME_W{1'b0}};
        phase_cnt_q <= {`TIME_W{1'b0}};
      end
    end
  end

  // =====================================================================
  // trip output
  // trip level follows state: it rises a cycle after the trip state and
  // falls on the same edge as the alarm code, so it never shows a blank alarm
  always @(posedge ref_clk) begin
    if (!rst_b)
      trip <= 1'b0;
    else
      trip <= (state_q == S_TRIP) && !clr_trip_q;
  end
endmodule // pump_start_flow_supervisor

// ==== pump_start_flow_supervisor_bench.sv ====
`timescale 1ns/1ns
`include "pump_consts.vh"
// =====================================================================
// bench top
module pump_start_flow_supervisor_bench;
  logic ref_clk = 1'h0, rst_b = 1'h0, cyc = 1'h0, stb = 1'h0, we = 1'h0;
  logic start_pin = 1'h0, stop_pin = 1'h0, open_cmd = 1'h0, speed_hi = 1'h0;
  logic [7:0] adr = 8'h00;
  logic [3:0] sel = 4'hf;
  logic [31:0] dat = 32'h0;
  logic [15:0] motor_speed = 16'h0;
  wire [31:0] wb_dat_o;
  wire wb_ack_o, ramp_enable, run_normal, flow_verifying, trip, flow_ok;
  wire [7:0] alarm_code;
  logic [63:0] exp_q[$];
  logic [63:0] e;
  int mismatches = 0, num_checks = 0, r;
  localparam logic [31:0] rv[8] = '{32'h64, 32'h96, 32'h0, 32'h12c, 32'h0, 32'h0, 32'h0, 32'h0};
  pump_start_flow_supervisor u_pump_start_flow_supervisor (.ref_clk(ref_clk), .rst_b(rst_b),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .start_pin(start_pin), .stop_pin(stop_pin),
    .flow_confirm_pin(flow_ok), .motor_speed(motor_speed), .ramp_enable(ramp_enable),
    .run_normal(run_normal), .flow_verifying(flow_verifying), .trip(trip), .alarm_code(alarm_code));
  flow_switch u_flow_switch (.ref_clk(ref_clk), .open_cmd(open_cmd), .flow_ok(flow_ok));
  initial begin
    forever #5 ref_clk = ~ref_clk;
  end
  // speed wanders at random inside the half of the range that speed_hi picks
  always @(posedge ref_clk) motor_speed <= {speed_hi, 15'($urandom)};
  task check(input logic [31:0] seen, input logic [31:0] expv);
    num_checks++;
    if (seen !== expv) begin
      mismatches++;
      $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, expv);
    end
  endtask
  task conclude;
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // one classic cycle; a read notes its masked expectation first
  task bus(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [31:0] m);
    int n;
    n = 0;
    if (!w) exp_q.push_back({m, d});
    @(posedge ref_clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat <= d;
    repeat (20) begin
      @(posedge ref_clk);
      if (wb_ack_o === 1'b1) break;
      n++;
    end
    if (n == 20) begin
      mismatches++;
      conclude();
    end
    cyc <= 1'b0;
    stb <= 1'b0;
    sel <= 4'hf;
  endtask
  task pin(input logic s, input int c);
    start_pin <= s;
    repeat (c) @(posedge ref_clk);
    start_pin <= 1'b0;
    repeat (c) @(posedge ref_clk);
  endtask
  // read data is judged at the ack edge against the oldest note
  always @(posedge ref_clk) begin
    if (wb_ack_o === 1'b1 && we === 1'b0) begin
      e = exp_q.pop_front();
      check(wb_dat_o & e[63:32], e[31:0]);
    end
  end
  initial begin
    r = $urandom(32'h802c);
    repeat (5) @(posedge ref_clk);
    rst_b <= 1'b1;
    // reset values, idle status, unmapped read
    foreach (rv[i]) bus(0, 8'h04 + 8'(4 * i), rv[i], 32'hffffffff);
    // time clamps and a narrow write
    bus(1, `REG_VALID_TIME, 32'h0, 32'h0);
    bus(0, `REG_VALID_TIME, 32'h1, 32'hffffffff);
    bus(1, `REG_VALID_TIME, 32'd9991, 32'h0);
    bus(1, `REG_VERIFY_TIME, 32'd2551, 32'h0);
    bus(0, `REG_VERIFY_TIME, 32'd2550, 32'hffffffff);
    r = 1 + $urandom % 2550;
    bus(1, `REG_VERIFY_TIME, r, 32'h0);
    bus(0, `REG_VERIFY_TIME, r, 32'hffffffff);
    @(posedge ref_clk); // the last release has its own time step
    sel <= 4'h3;
    bus(1, `REG_VALID_TIME, 32'h5, 32'h0);
    bus(0, `REG_VALID_TIME, 32'd9990, 32'hffffffff);
    // no flow indication while the input is unassigned
    pin(1'b1, 6);
    check(flow_verifying, 1'b0);
    check(run_normal, 1'b1);
    check(ramp_enable, 1'b1);
    stop_pin <= 1'b1;
    bus(1, `REG_CTRL, 32'h1, 32'h0);
    stop_pin <= 1'b0;
    // start enters validation with the panel indication
    pin(1'b1, 6);
    check(flow_verifying, 1'b1);
    bus(0, `REG_STATUS, 32'h11, 32'h71);
    // stop mid-validation returns to idle quietly
    stop_pin <= 1'b1;
    repeat (6) @(posedge ref_clk);
    bus(0, `REG_STATUS, 32'h0, 32'h77);
    bus(0, `REG_ALARM, 32'h0, 32'hff);
    stop_pin <= 1'b0;
    // flow seen, then lost during verification
    pin(1'b1, 3);
    open_cmd <= 1'b1;
    repeat (12) @(posedge ref_clk);
    bus(0, `REG_STATUS, 32'h21, 32'h73);
    open_cmd <= 1'b0;
    repeat (8) @(posedge ref_clk);
    check(trip, 1'b1);
    check(alarm_code, `ALARM_NO_FLOW);
    // trip survives start and stop until cleared
    pin(1'b1, 6);
    stop_pin <= 1'b1;
    bus(0, `REG_STATUS, 32'h54, 32'h77);
    stop_pin <= 1'b0;
    bus(1, `REG_CTRL, 32'h5, 32'h0);
    repeat (4) @(posedge ref_clk);
    bus(0, `REG_STATUS, 32'h0, 32'h77);
    // hold-off at the deadline: no ramp, low-speed trip instead
    bus(1, `REG_DEADLINE, 32'h0, 32'h0);
    bus(1, `REG_CTRL, 32'h2, 32'h0);
    pin(1'b1, 6);
    check(ramp_enable, 1'b0);
    check(run_normal, 1'b0);
    check(trip, 1'b1);
    check(alarm_code, `ALARM_LOW_SPEED);
    // runs while speed holds the floor, trips once it sags below
    bus(1, `REG_DEADLINE, 32'h12c, 32'h0);
    bus(1, `REG_SPEED_FLOOR, 32'h8000, 32'h0);
    speed_hi <= 1'b1;
    bus(1, `REG_CTRL, 32'h6, 32'h0);
    pin(1'b1, 6);
    check(run_normal, 1'b1);
    check(trip, 1'b0);
    speed_hi <= 1'b0;
    repeat (5) @(posedge ref_clk);
    check(trip, 1'b1);
    check(run_normal, 1'b0);
    check(alarm_code, `ALARM_LOW_SPEED);
    conclude();
  end
endmodule // pump_start_flow_supervisor_bench

// ==== sync2.v ====
`timescale 1ns/1ns
// =====================================================================
// two-flop synchroniser for pin inputs
module sync2 (
  input wire ref_clk,
  input wire rst_b,
  input wire din,
  output reg dout
);
  reg meta_q;
  // first flop feeds only the second
  always @(posedge ref_clk) begin
    if (!rst_b) begin
      meta_q <= 1'b0;
      dout <= 1'b0;
    end else begin
      meta_q <= din;
      dout <= meta_q;
    end
  end
endmodule // sync2

// ==== tick_divider.v ====
`timescale 1ns/1ns
`include "pump_consts.vh"
// =====================================================================
// tenth-second time base
module tick_divider (
  input wire ref_clk,
  input wire rst_b,
  output reg tick
);
  reg [`TICK_CNT_W-1:0] cnt_q;
  // terminal count cut to the counter width on purpose
  localparam integer TICK_LAST_I = `TICK_CYCLES - 1;
  localparam [`TICK_CNT_W-1:0] TICK_LAST = TICK_LAST_I[`TICK_CNT_W-1:0];
  // free-running divider; one-cycle enable every 100 ms
  always @(posedge ref_clk) begin
    if (!rst_b) begin
      cnt_q <= {`TICK_CNT_W{1'b0}};
      tick <= 1'b0;
    end else if (cnt_q == TICK_LAST) begin
      cnt_q <= {`TICK_CNT_W{1'b0}};
      tick <= 1'b1;
    end else begin
      cnt_q <= cnt_q + 1'b1;
      tick <= 1'b0;
    end
  end
endmodule // tick_divider
